// ---- hw/cs_buffer_map.svh ----
/*
  Address map, field positions, reset values and frame counts of the
  channel-status block buffer. Included by every design file that needs them;
  assumes a byte-wide control port with 8-bit addresses.
*/
`ifndef CS_BUFFER_MAP_SVH
`define CS_BUFFER_MAP_SVH

// Block geometry
`define CSB_WORDS        24
`define FRAMES_PER_BLOCK 8'd192
`define LAST_FRAME       8'd191

// Control-port addresses
`define ADDR_CTRL    8'h1E
`define ADDR_STAT    8'h1F
`define ADDR_CS_BASE 8'h20
`define ADDR_CS_LAST 8'h37
`define ADDR_U_BASE  8'h38
`define ADDR_U_LAST  8'h4F

// Control register fields and reset
`define CTRL_INHIBIT  0
`define CTRL_RESERVE  1
`define CTRL_ONE_BYTE 2
`define CTRL_CHAN_B   3
`define CTRL_IRQ_EN   4
`define CTRL_RESET    5'h00

// Leading words kept for host writes
`define RESERVED_BYTES 5

// Quiet time after a transfer, in frames
`define HOLDOFF_FRAMES 24

`endif

// ---- hw/cs_buffer_pkg.sv ----
/*
  Types shared by the channel-status block buffer files.
  Assumes nothing of its surroundings.
*/
package cs_buffer_pkg;

  // Bits recovered from one frame, both subframes
  typedef struct packed {
    logic cs_a;
    logic cs_b;
    logic u_a;
    logic u_b;
  } rx_bits_t;

  // Control register, bit 4 down to bit 0
  typedef struct packed {
    logic irq_en;
    logic chan_b;
    logic one_byte;
    logic reserve;
    logic inhibit;
  } ctrl_t;

  // Two-byte access phase
  typedef enum logic {
    PH_FIRST  = 1'b0,
    PH_SECOND = 1'b1
  } phase_t;

endpackage : cs_buffer_pkg

// ---- hw/rx_block_collector.sv ----
/*
  Receive-side block buffer: gathers channel-status and user bits frame by
  frame into one block image. Assumes frame_stb is a one-cycle pulse per frame
  and block_start marks the first frame of a block in the same cycle.
*/
`include "cs_buffer_map.svh"

module rx_block_collector #(
  parameter int WORDS = `CSB_WORDS
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // Frame bits from the receiver
  input  wire logic                     frame_stb,
  input  wire logic                     block_start,
  input  wire cs_buffer_pkg::rx_bits_t  bits,
  // Block image and completion pulse
  output logic [WORDS*16-1:0]           d_cs,
  output logic [WORDS*16-1:0]           d_u,
  output logic                          block_done
);

  logic [7:0]          frame_q, frame_d;  // Next frame slot
  logic                armed_q, armed_d;  // Block start seen
  logic [WORDS*16-1:0] cs_q, cs_d;        // C words, A high, B low
  logic [WORDS*16-1:0] u_q, u_d;          // U words, interleaved
  logic                done_q, done_d;    // Full block present

  // Place each frame's bits; a new block start discards a partial block
  always_comb begin
    logic [7:0] idx;
    int         w;
    int         b;
    idx     = block_start ? 8'h00 : frame_q;
    w       = int'(idx[7:3]);
    b       = int'(idx[2:0]);
    frame_d = frame_q;
    armed_d = armed_q;
    cs_d    = cs_q;
    u_d     = u_q;
    done_d  = 1'b0;
    if (frame_stb && (block_start || armed_q)) begin
      // Earliest bit lands in the byte MSB
      cs_d[w*16+15-b]  = bits.cs_a;
      cs_d[w*16+7-b]   = bits.cs_b;
      // U pairs interleave from bit 15 down
      u_d[w*16+15-2*b] = bits.u_a;
      u_d[w*16+14-2*b] = bits.u_b;
      if (idx == `LAST_FRAME) begin
        // Only a full 192-frame run completes a block
        done_d  = 1'b1;
        armed_d = 1'b0;
        frame_d = 8'h00;
      end else begin
        armed_d = 1'b1;
        frame_d = idx + 8'h01;
      end
    end
  end

  // Register the collector state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frame_q <= 8'h00;
      armed_q <= 1'b0;
      cs_q    <= '0;
      u_q     <= '0;
      done_q  <= 1'b0;
    end else begin
      frame_q <= frame_d;
      armed_q <= armed_d;
      cs_q    <= cs_d;
      u_q     <= u_d;
      done_q  <= done_d;
    end
  end

  assign d_cs       = cs_q;
  assign d_u        = u_q;
  assign block_done = done_q;

  // First bit of a block goes to the MSB of byte 0
  a_msb_first: assert property (@(posedge clk) disable iff (!reset_n)
    frame_stb && block_start |=> cs_q[15] == $past(bits.cs_a) && u_q[15] == $past(bits.u_a))
    else $error("first channel-status bit not in MSB");

  // Completion only after the last frame slot was filled
  a_done_full_block: assert property (@(posedge clk) disable iff (!reset_n)
    done_q |-> $past(frame_stb) && $past(frame_q) == `LAST_FRAME && frame_q == 8'h00)
    else $error("block reported complete early");

endmodule : rx_block_collector

// ---- hw/channel_status_block_buffer.sv ----
/*
  Double-buffered channel-status and user-data store with a byte-wide
  control-port register access, transfer pulse, inhibit and leading-byte
  reservation. Assumes the receiver supplies per-frame strobes and that the
  control-port protocol engine presents one-cycle read and write strobes.
*/
`include "cs_buffer_map.svh"

module channel_status_block_buffer #(
  parameter int WORDS   = `CSB_WORDS,
  parameter int RSV     = `RESERVED_BYTES,
  parameter int HOLDOFF = `HOLDOFF_FRAMES
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // Receiver frame timing and bits
  input  wire logic                    frame_stb,
  input  wire logic                    block_start,
  input  wire cs_buffer_pkg::rx_bits_t rx_bits,
  // Control-port register access
  input  wire logic [7:0]              cp_addr,
  input  wire logic                    cp_wr,
  input  wire logic [7:0]              cp_wdata,
  input  wire logic                    cp_rd,
  output logic [7:0]                   cp_rdata,
  output logic                         cp_rvalid,
  // Transfer interrupt
  output logic                         xfer_irq
);

  logic [WORDS*16-1:0] d_cs;        // Receive-side C image
  logic [WORDS*16-1:0] d_u;         // Receive-side U image
  logic                block_done;  // Complete block ready
  logic                xfer;        // Copy happens this cycle

  // Receive-side buffer
  rx_block_collector #(
    .WORDS       (WORDS)
  ) u_rx (
    .clk         (clk),
    .reset_n     (reset_n),
    .frame_stb   (frame_stb),
    .block_start (block_start),
    .bits        (rx_bits),
    .d_cs        (d_cs),
    .d_u         (d_u),
    .block_done  (block_done)
  );

  cs_buffer_pkg::ctrl_t  ctrl_q, ctrl_d;        // Control register
  logic [WORDS*16-1:0]   e_cs_q, e_cs_d;        // Host-visible C words
  logic [WORDS*16-1:0]   e_u_q, e_u_d;          // Host-visible U words
  logic [4:0]            hold_q, hold_d;        // Frames left in quiet time
  logic                  seen_q, seen_d;        // Transfer since status read
  logic                  irq_q, irq_d;          // Interrupt pulse
  cs_buffer_pkg::phase_t rph_q, rph_d;          // Read byte phase
  cs_buffer_pkg::phase_t wph_q, wph_d;          // Write byte phase
  logic [7:0]            pend_q, pend_d;        // Second byte, caught at first
  logic [7:0]            rdata_q, rdata_d;      // Read data
  logic                  rvalid_q, rvalid_d;    // Read data valid

  // Address decode
  logic       in_cs;       // C word window
  logic       in_u;        // U word window
  logic [7:0] cs_off;      // C word index
  logic [7:0] u_off;       // U word index
  logic       host_wr_ok;  // Write into a reserved word
  logic       wr_a;        // Write targets the A byte

  assign in_cs  = cp_addr >= `ADDR_CS_BASE && cp_addr <= `ADDR_CS_LAST;
  assign in_u   = cp_addr >= `ADDR_U_BASE && cp_addr <= `ADDR_U_LAST;
  assign cs_off = cp_addr - `ADDR_CS_BASE;
  assign u_off  = cp_addr - `ADDR_U_BASE;
  // Only reserved words accept writes, and only in reserve mode
  assign host_wr_ok = cp_wr && in_cs && ctrl_q.reserve && int'(cs_off) < RSV;
  assign wr_a       = ctrl_q.one_byte ? !ctrl_q.chan_b : (wph_q == cs_buffer_pkg::PH_FIRST);

  // Whole block, not inhibited, quiet time over
  assign xfer = block_done && !ctrl_q.inhibit && hold_q == 5'h00;

  // Host buffer: one-cycle copy keeps each read consistent
  always_comb begin
    e_cs_d = e_cs_q;
    e_u_d  = e_u_q;
    if (xfer) begin
      e_u_d = d_u;
      for (int w = 0; w < WORDS; w++) begin
        // Reserved leading words are skipped by the copy
        if (!(ctrl_q.reserve && w < RSV)) begin
          e_cs_d[w*16 +: 16] = d_cs[w*16 +: 16];
        end
      end
    end
    // Host value wins and then stays until rewritten, while reserve mode stays set
    if (host_wr_ok) begin
      if (wr_a) begin
        e_cs_d[int'(cs_off)*16+8 +: 8] = cp_wdata;
      end else begin
        e_cs_d[int'(cs_off)*16 +: 8] = cp_wdata;
      end
    end
  end

  // Control, quiet-time counter, status and interrupt
  always_comb begin
    ctrl_d = ctrl_q;
    hold_d = hold_q;
    seen_d = seen_q;
    wph_d  = wph_q;
    irq_d  = xfer && ctrl_q.irq_en;
    if (cp_wr && cp_addr == `ADDR_CTRL) begin
      ctrl_d = cs_buffer_pkg::ctrl_t'(cp_wdata[4:0]);
    end
    // Two-byte writes alternate A then B
    if (host_wr_ok && !ctrl_q.one_byte) begin
      wph_d = (wph_q == cs_buffer_pkg::PH_FIRST) ? cs_buffer_pkg::PH_SECOND : cs_buffer_pkg::PH_FIRST;
    end
    // Frame-paced quiet time; gives the host room to read
    if (xfer) begin
      hold_d = 5'(HOLDOFF);
    end else if (frame_stb && hold_q != 5'h00) begin
      hold_d = hold_q - 5'h01;
    end
    // Status read clears, a new transfer in that cycle wins
    if (cp_rd && cp_addr == `ADDR_STAT && rph_q == cs_buffer_pkg::PH_FIRST) begin
      seen_d = 1'b0;
    end
    if (xfer) begin
      seen_d = 1'b1;
    end
  end

  // Read path; second byte is latched with the first
  always_comb begin
    rph_d    = rph_q;
    pend_d   = pend_q;
    rdata_d  = rdata_q;
    rvalid_d = cp_rd;
    if (cp_wr) begin
      // A write restarts the byte pairing
      rph_d = cs_buffer_pkg::PH_FIRST;
    end else if (cp_rd) begin
      rdata_d = 8'h00;
      if (rph_q == cs_buffer_pkg::PH_SECOND) begin
        rdata_d = pend_q;
        rph_d   = cs_buffer_pkg::PH_FIRST;
      end else if (in_cs) begin
        if (ctrl_q.one_byte) begin
          // Single byte from the selected channel
          rdata_d = ctrl_q.chan_b ? e_cs_q[int'(cs_off)*16 +: 8] : e_cs_q[int'(cs_off)*16+8 +: 8];
        end else begin
          // A byte now, B byte on the next read
          rdata_d = e_cs_q[int'(cs_off)*16+8 +: 8];
          pend_d  = e_cs_q[int'(cs_off)*16 +: 8];
          rph_d   = cs_buffer_pkg::PH_SECOND;
        end
      end else if (in_u) begin
        // User words always read as two bytes
        rdata_d = e_u_q[int'(u_off)*16+8 +: 8];
        pend_d  = e_u_q[int'(u_off)*16 +: 8];
        rph_d   = cs_buffer_pkg::PH_SECOND;
      end else if (cp_addr == `ADDR_CTRL) begin
        rdata_d = {3'h0, ctrl_q};
      end else if (cp_addr == `ADDR_STAT) begin
        rdata_d = {6'h00, hold_q != 5'h00, seen_q};
      end
    end
  end

  // Register all state
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q   <= cs_buffer_pkg::ctrl_t'(`CTRL_RESET);
      e_cs_q   <= '0;
      e_u_q    <= '0;
      hold_q   <= 5'h00;
      seen_q   <= 1'b0;
      irq_q    <= 1'b0;
      rph_q    <= cs_buffer_pkg::PH_FIRST;
      wph_q    <= cs_buffer_pkg::PH_FIRST;
      pend_q   <= 8'h00;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      e_cs_q   <= e_cs_d;
      e_u_q    <= e_u_d;
      hold_q   <= hold_d;
      seen_q   <= seen_d;
      irq_q    <= irq_d;
      rph_q    <= rph_d;
      wph_q    <= wph_d;
      pend_q   <= pend_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign cp_rdata  = rdata_q;
  assign cp_rvalid = rvalid_q;
  assign xfer_irq  = irq_q;

  // Helper bytes for the read checks
  logic [7:0] chk_a;
  logic [7:0] chk_b;
  assign chk_a = in_cs ? e_cs_q[int'(cs_off)*16+8 +: 8] : 8'h00;
  assign chk_b = in_cs ? e_cs_q[int'(cs_off)*16 +: 8] : 8'h00;

  sequence s_cs_first_rd;
    cp_rd && !cp_wr && in_cs && rph_q == cs_buffer_pkg::PH_FIRST;
  endsequence

  // Second strobe of a pair, phase still pending
  sequence s_second_rd;
    cp_rd && !cp_wr && rph_q == cs_buffer_pkg::PH_SECOND;
  endsequence

  a_copy_whole_block: assert property (@(posedge clk) disable iff (!reset_n)
    xfer |=> e_u_q == $past(d_u))
    else $error("user buffer not copied whole");

  a_inhibit_holds: assert property (@(posedge clk) disable iff (!reset_n)
    block_done && ctrl_q.inhibit |=> e_u_q == $past(e_u_q) && !xfer_irq)
    else $error("transfer despite inhibit");

  a_quiet_time: assert property (@(posedge clk) disable iff (!reset_n)
    xfer |=> hold_q == 5'(HOLDOFF))
    else $error("quiet time not loaded after transfer");

  a_quiet_count: assert property (@(posedge clk) disable iff (!reset_n)
    !xfer && frame_stb && hold_q != 5'h00 |=> hold_q == $past(hold_q) - 5'h01)
    else $error("quiet time not counted per frame");

  a_irq_on_xfer: assert property (@(posedge clk) disable iff (!reset_n)
    xfer_irq == $past(block_done && !ctrl_q.inhibit && hold_q == 5'h00 && ctrl_q.irq_en))
    else $error("interrupt does not track transfer");

  a_reserve_kept: assert property (@(posedge clk) disable iff (!reset_n)
    xfer && ctrl_q.reserve && !cp_wr |=> e_cs_q[RSV*16-1:0] == $past(e_cs_q[RSV*16-1:0]))
    else $error("reserved bytes overwritten");

  a_two_byte_order: assert property (@(posedge clk) disable iff (!reset_n)
    s_cs_first_rd ##0 !ctrl_q.one_byte |=> cp_rvalid && cp_rdata == $past(chk_a))
    else $error("two-byte read order wrong");

  // B byte comes from the word latched at the first strobe
  a_two_byte_second: assert property (@(posedge clk) disable iff (!reset_n)
    s_cs_first_rd ##0 !ctrl_q.one_byte ##2 s_second_rd |=> cp_rvalid && cp_rdata == $past(chk_b, 3))
    else $error("two-byte read second byte wrong");

  a_one_byte_sel: assert property (@(posedge clk) disable iff (!reset_n)
    s_cs_first_rd ##0 ctrl_q.one_byte |=> cp_rdata == ($past(ctrl_q.chan_b) ? $past(chk_b) : $past(chk_a)))
    else $error("one-byte read picks wrong channel");

  a_u_two_byte: assert property (@(posedge clk) disable iff (!reset_n)
    cp_rd && !cp_wr && in_u && rph_q == cs_buffer_pkg::PH_FIRST |=> rph_q == cs_buffer_pkg::PH_SECOND)
    else $error("user read not in two-byte mode");

endmodule : channel_status_block_buffer

// ---- test/host_port_model.sv ----
/*
  Host microcontroller model on the control port: one-cycle byte writes
  and strobed byte reads. Assumes the block answers a read one clock later.
*/
module host_port_model (
  // Clock
  input  wire logic       clk,
  // Strobes towards the block
  output logic [7:0]      cp_addr,
  output logic            cp_wr,
  output logic [7:0]      cp_wdata,
  output logic            cp_rd,
  // Read answer
  input  wire logic [7:0] cp_rdata,
  input  wire logic       cp_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle port at time zero
  initial begin
    cp_addr  = 8'h00;
    cp_wdata = 8'h00;
    cp_wr    = 1'b0;
    cp_rd    = 1'b0;
  end

  // One write strobe, launched on a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cp_addr  = a;
    cp_wdata = d;
    cp_wr    = 1'b1;
    @(negedge clk);
    cp_wr    = 1'b0;
    // Released lines must not keep showing the old value
    cp_addr  = ~a;
    cp_wdata = ~d;
  endtask : wr

  // One read strobe; answer awaited for a bounded time, else unknown
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hXX;
    @(negedge clk);
    cp_addr = a;
    cp_rd   = 1'b1;
    @(negedge clk);
    cp_rd   = 1'b0;
    cp_addr = ~a;
    for (int i = 0; i < 3; i++) begin
      if (cp_rvalid === 1'b1) begin
        d = cp_rdata;
        break;
      end
      @(negedge clk);
    end
  endtask : rd

endmodule : host_port_model

// ---- test/channel_status_block_buffer_bench.sv ----
/*
  Self-checking bench for the channel-status block buffer. The bench plays
  the receiver; the host model drives the control port.
*/
`define CHK(what, exp, got) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("BAD %s expected %0h seen %0h", what, exp, got); \
  end \
end

module channel_status_block_buffer_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                    clk;          // 200 MHz clock
  logic                    reset_n;      // Synchronous reset
  logic                    frame_stb;    // Frame strobe
  logic                    block_start;  // Frame 0 marker
  cs_buffer_pkg::rx_bits_t rx_bits;      // Bits of one frame
  logic [7:0]              cp_addr;
  logic                    cp_wr;
  logic [7:0]              cp_wdata;
  logic                    cp_rd;
  logic [7:0]              cp_rdata;
  logic                    cp_rvalid;
  logic                    xfer_irq;
  int                      failures   = 0;
  int                      num_checks = 0;
  int                      irq_cycles = 0;  // Cycles with the pulse high

  channel_status_block_buffer DUT (
    .clk(clk), .reset_n(reset_n), .frame_stb(frame_stb), .block_start(block_start),
    .rx_bits(rx_bits), .cp_addr(cp_addr), .cp_wr(cp_wr), .cp_wdata(cp_wdata),
    .cp_rd(cp_rd), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid), .xfer_irq(xfer_irq)
  );

  host_port_model HOST (
    .clk(clk), .cp_addr(cp_addr), .cp_wr(cp_wr), .cp_wdata(cp_wdata),
    .cp_rd(cp_rd), .cp_rdata(cp_rdata), .cp_rvalid(cp_rvalid)
  );

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Pulse counter; a stuck pulse shows up as a large count
  // Sampled mid-cycle, where the registered pulse has settled
  always @(negedge clk) begin
    if (xfer_irq === 1'b1) irq_cycles <= irq_cycles + 1;
  end

  // Verdict and end of run
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // Stream n back-to-back frames; pattern 1 sparse marks, 2 all-ones C
  task automatic frames(input int n, input bit start, input int pat);
    for (int f = 0; f < n; f++) begin
      @(negedge clk);
      frame_stb    = 1'b1;
      block_start  = start && f == 0;
      rx_bits.cs_a = pat == 2 || (pat == 1 && f % 40 == 0);
      rx_bits.cs_b = pat == 2 || (pat == 1 && f == 1);
      rx_bits.u_a  = pat == 1 && f == 0;
      rx_bits.u_b  = pat == 1 && f == 0;
    end
    @(negedge clk);
    frame_stb   = 1'b0;
    block_start = 1'b0;
    rx_bits     = ~rx_bits;
    // Let transfer and pulse settle
    repeat (4) @(negedge clk);
  endtask : frames

  // Single-strobe read compare
  task automatic chk1(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    HOST.rd(a, d);
    `CHK("read byte", e, d)
  endtask : chk1

  // Two-strobe read compare, first then second byte
  task automatic chk_pair(input logic [7:0] a, input logic [7:0] ea, input logic [7:0] eb);
    chk1(a, ea);
    chk1(a, eb);
  endtask : chk_pair

  // Reset values and unmapped read
  task automatic t_reset;
    chk1(8'h1E, 8'h00);
    chk_pair(8'h20, 8'h00, 8'h00);
    chk1(8'h80, 8'h00);
  endtask : t_reset

  // Full block, bit placement and quiet time
  task automatic t_block;
    HOST.wr(8'h1E, 8'h10);
    frames(192, 1'b1, 1);
    `CHK("irq cycles", 1, irq_cycles)
    chk_pair(8'h20, 8'h80, 8'h40);
    chk_pair(8'h25, 8'h80, 8'h00);
    chk_pair(8'h38, 8'hC0, 8'h00);
    chk1(8'h1F, 8'h03);
    frames(23, 1'b0, 0);
    chk1(8'h1F, 8'h02);
    frames(1, 1'b0, 0);
    chk1(8'h1F, 8'h00);
  endtask : t_block

  // Partial block and inhibited block leave the host copy alone
  task automatic t_inhibit;
    frames(100, 1'b1, 2);
    `CHK("irq cycles", 1, irq_cycles)
    HOST.wr(8'h1E, 8'h11);
    frames(192, 1'b1, 2);
    `CHK("irq cycles", 1, irq_cycles)
    chk_pair(8'h20, 8'h80, 8'h40);
  endtask : t_inhibit

  // Reserved leading words survive a transfer
  task automatic t_reserve;
    HOST.wr(8'h1E, 8'h12);
    HOST.wr(8'h20, 8'h55);
    HOST.wr(8'h20, 8'hAA);
    frames(192, 1'b1, 2);
    `CHK("irq cycles", 2, irq_cycles)
    chk_pair(8'h20, 8'h55, 8'hAA);
    chk_pair(8'h24, 8'h00, 8'h00);
    chk_pair(8'h25, 8'hFF, 8'hFF);
  endtask : t_reserve

  // One-byte access and writes refused without reservation
  task automatic t_one_byte;
    HOST.wr(8'h1E, 8'h0C);
    chk1(8'h20, 8'hAA);
    HOST.wr(8'h1E, 8'h04);
    chk1(8'h20, 8'h55);
    HOST.wr(8'h20, 8'h11);
    chk1(8'h20, 8'h55);
  endtask : t_one_byte

  // Reset in mid-run, then a block with the interrupt disabled
  task automatic t_mid_reset;
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    chk1(8'h1E, 8'h00);
    chk_pair(8'h20, 8'h00, 8'h00);
    frames(192, 1'b1, 2);
    `CHK("irq cycles", 2, irq_cycles)
    chk_pair(8'h20, 8'hFF, 8'hFF);
    chk1(8'h1F, 8'h03);
  endtask : t_mid_reset

  // Main sequence
  initial begin
    reset_n     = 1'b0;
    frame_stb   = 1'b0;
    block_start = 1'b0;
    rx_bits     = '0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_block();
    t_inhibit();
    t_reserve();
    t_one_byte();
    t_mid_reset();
    results();
  end

  // Watchdog, well beyond the roughly 1000 cycles the run needs
  initial begin
    #50000;
    failures++;
    results();
  end

endmodule : channel_status_block_buffer_bench
